// ===== design/tsr_pkg.sv
// Shared constants and types for the time-signal receiver front end
package tsr_pkg;
  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 25_000_000;
  localparam int CLK_PERIOD_NS = 40;
  localparam int MS_PER_S = 1000;
  localparam int BIT0_MS = 100;
  localparam int BIT1_MS = 200;
  localparam int SEC_MS = 1000;
  localparam int GAP_MS = 2000;
  localparam int TIMEOUT_MS = 2500;
  localparam int TOL_STEP_MS = 8;
  localparam int PULL_TRY_MS = 3000;
  localparam int FRAME_BITS = 59;
  // ---------------------------------------------------------------
  // Register map and fields
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] SYNC_OFS = 8'h04;
  localparam logic [7:0] TIME_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0c;
  localparam logic [7:0] INT_STAT_OFS = 8'h10;
  localparam logic [7:0] INT_MASK_OFS = 8'h14;
  localparam int PULL_LSB = 0;
  localparam int INV_LSB = 2;
  localparam int PSINV_BIT = 4;
  localparam int LED_LSB = 5;
  localparam int TOL_LSB = 8;
  localparam int BRIGHT_LSB = 0;
  localparam int SHOUR_LSB = 8;
  localparam int SEC_LSB = 0;
  localparam int MIN_LSB = 8;
  localparam int HOUR_LSB = 16;
  localparam int CNT_LSB = 8;
  localparam int MIN_UNITS_LSB = 21;
  localparam int MIN_TENS_LSB = 25;
  localparam int HOUR_UNITS_LSB = 29;
  localparam int HOUR_TENS_LSB = 33;
  localparam logic [4:0] BRIGHT_MAX = 5'h19;
  localparam logic [4:0] HOUR_MAX = 5'h17;
  localparam logic [2:0] TOL_MIN = 3'h1;
  localparam logic [2:0] TOL_MAX = 3'h6;
  localparam logic [1:0] LED_MAX = 2'h2;
  localparam logic [2:0] TOL_RST = 3'h1;
  localparam logic [4:0] BRIGHT_RST = 5'h05;
  localparam logic [4:0] SHOUR_RST = 5'h03;
  // Interrupt event bits
  localparam int EV_SEARCH = 0;
  localparam int EV_READ = 1;
  localparam int EV_SYNC = 2;
  localparam int EV_LOST = 3;
  localparam int EV_START = 4;
  localparam int EV_W = 5;
  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {automatic_setting, forced_on, forced_off} sel_t;
  typedef enum logic [1:0] {idle_state, no_signal_state, search_state,
                            frame_reading_state} phase_t;
  typedef struct packed {
    sel_t pull_mode;
    sel_t inv_mode;
    logic ps_inv;
    logic [1:0] led_mode;
    logic [2:0] tol;
    logic [4:0] rx_bright;
    logic [4:0] sync_hour;
  } cfg_t;
  localparam cfg_t CFG_RST = '{automatic_setting, automatic_setting, 1'b0, 2'h0,
                               TOL_RST, BRIGHT_RST, SHOUR_RST};
  typedef struct packed {
    phase_t state;
    cfg_t cfg;
    logic prev;
    logic w_ok;
    logic [11:0] width;
    logic [11:0] period;
    logic [9:0] win;
    logic [9:0] hi;
    logic [9:0] lo;
    logic auto_inv;
    logic auto_pull;
    logic [11:0] nosig_ms;
    logic [5:0] bit_cnt;
    logic [FRAME_BITS-1:0] frame;
    logic [9:0] sec_ms;
    logic [5:0] sec;
    logic [5:0] min;
    logic [4:0] hour;
    logic synced;
    logic ever;
    logic [EV_W-1:0] istat;
    logic [EV_W-1:0] imask;
    logic [31:0] rdata;
    logic a_act;
    logic a_wr;
    logic [7:0] a_addr;
  } st_t;
endpackage

// ===== design/ms_tick.sv
// Free-running divider giving one-cycle millisecond ticks
module ms_tick #(
  parameter int CYCLES = 25000
) (
  input wire logic clk,
  input wire logic rst,
  output logic tick
);
  logic [31:0] cnt;

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt <= 32'h0;
      tick <= 1'b0;
    end else begin
      tick <= (cnt == 32'(CYCLES - 1));
      cnt <= (cnt == 32'(CYCLES - 1)) ? 32'h0 : cnt + 32'h1;
    end
  end
endmodule // ms_tick

// ===== design/span_check.sv
// Window compare: value lies within centre plus or minus a tolerance
module span_check #(
  parameter int W = 12
) (
  input wire logic [W-1:0] value,
  input wire logic [W-1:0] centre,
  input wire logic [W-1:0] tol,
  output logic ok
);
  // One extra bit keeps the sums from wrapping
  assign ok = ({1'b0, value} + {1'b0, tol} >= {1'b0, centre}) &&
              ({1'b0, value} <= {1'b0, centre} + {1'b0, tol});
endmodule // span_check

// ===== design/time_signal_receiver_sync.sv
// Receiver front end, synchronisation states and time keeping with AHB-Lite registers
//
// How it works
// - Unclean pulses show no-signal; clean pulses start the hunt for the minute gap.
// - After the gap, read one full frame; time appears after sixty more seconds.
// - Receive LED follows the conditioned input pulses, once a second when good.
// - Reception brightness 0 to 25; zero blanks display, status via decimal points.
// - Brightness above zero keeps display dimmed at that level during synchronisation.
// - Synchronisation hour 0 to 23 starts a daily attempt in that hour.
// - LED mode 0 until first sync, 1 while unsynchronised, 2 always.
// - Pull-up automatic by default, or forced on, or forced off.
// - Input polarity automatic by default, forced inverted, or forced straight.
// - Receiver power output enables module low when inverted, high otherwise.
// - Pulse tolerance 1 tightest to 6 loosest.
// - Manually set time runs unsynchronised until the next scheduled attempt.
// - Automatic mode finds pull-up need and inversion from the received input.
module time_signal_receiver_sync import tsr_pkg::*; #(
  parameter int MS_CYCLES = CLK_HZ / MS_PER_S
) (
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic DATA_IN,
  output logic PULLUP_EN,
  output logic RX_POWER,
  output logic RX_LED,
  output logic IRQ,
  output logic DISP_BLANK,
  output logic DISP_DIM,
  output logic [4:0] DISP_LEVEL,
  output logic [1:0] STATUS_CODE
);
  st_t s;
  st_t next_s;
  logic tick;
  logic sec_tick;
  logic inv_eff;
  logic cond;
  logic rise;
  logic fall;
  logic w0_ok;
  logic w1_ok;
  logic p1_ok;
  logic p2_ok;
  logic led_en;
  logic attempting;
  logic ap;
  logic wr_time;
  logic [11:0] tol_ms;
  logic [EV_W-1:0] ev;
  logic [EV_W-1:0] clr;

  // ---------------------------------------------------------------
  // Input conditioning and measurement
  // ---------------------------------------------------------------
  ms_tick #(.CYCLES(MS_CYCLES)) u_tick (.clk(CORE_CLK), .rst(SYS_RST), .tick(tick));

  assign tol_ms = 12'(s.cfg.tol) * 12'(TOL_STEP_MS);
  span_check #(.W(12)) u_w0 (.value(s.width), .centre(12'(BIT0_MS)), .tol(tol_ms), .ok(w0_ok));
  span_check #(.W(12)) u_w1 (.value(s.width), .centre(12'(BIT1_MS)), .tol(tol_ms), .ok(w1_ok));
  span_check #(.W(12)) u_p1 (.value(s.period), .centre(12'(SEC_MS)), .tol(tol_ms), .ok(p1_ok));
  span_check #(.W(12)) u_p2 (.value(s.period), .centre(12'(GAP_MS)), .tol(tol_ms), .ok(p2_ok));

  assign inv_eff = (s.cfg.inv_mode == forced_on) ? 1'b1 :
                   (s.cfg.inv_mode == forced_off) ? 1'b0 : s.auto_inv;
  assign cond = DATA_IN ^ inv_eff;
  assign rise = cond && !s.prev;
  assign fall = !cond && s.prev;
  assign sec_tick = tick && (s.sec_ms == 10'(SEC_MS - 1));
  assign attempting = (s.state != idle_state);
  assign ap = HSEL && HTRANS[1] && HREADY && (HSIZE == 3'h2);
  assign wr_time = s.a_act && s.a_wr && (s.a_addr == TIME_OFS);

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    next_s = s;
    ev = '0;
    clr = '0;
    next_s.prev = cond;
    // Pulse width and period in milliseconds, both saturating
    if (rise) begin
      next_s.width = 12'h0;
      next_s.period = 12'h0;
    end else if (tick) begin
      if (s.prev && s.width != 12'hfff) next_s.width = s.width + 12'h1;
      if (s.period != 12'hfff) next_s.period = s.period + 12'h1;
    end
    // Polarity vote over each second on the raw input
    if (tick) begin
      if (s.win == 10'(SEC_MS - 1)) begin
        next_s.auto_inv = (s.hi > s.lo);
        next_s.win = 10'h0;
        next_s.hi = 10'h0;
        next_s.lo = 10'h0;
      end else begin
        next_s.win = s.win + 10'h1;
        if (DATA_IN) next_s.hi = s.hi + 10'h1;
        else next_s.lo = s.lo + 10'h1;
      end
    end
    // Time of day
    if (tick) next_s.sec_ms = sec_tick ? 10'h0 : s.sec_ms + 10'h1;
    if (sec_tick) begin
      next_s.sec = (s.sec == 6'h3b) ? 6'h0 : s.sec + 6'h1;
      if (s.sec == 6'h3b) begin
        next_s.min = (s.min == 6'h3b) ? 6'h0 : s.min + 6'h1;
        if (s.min == 6'h3b) next_s.hour = (s.hour == HOUR_MAX) ? 5'h0 : s.hour + 5'h1;
      end
    end
    if (fall) next_s.w_ok = w0_ok || w1_ok;
    unique case (s.state)
      idle_state: begin
        next_s.w_ok = 1'b0;
        if (sec_tick && s.hour == s.cfg.sync_hour && s.min == 6'h0 && s.sec == 6'h0) begin
          next_s.state = no_signal_state;
          ev[EV_START] = 1'b1;
        end
      end
      no_signal_state: begin
        // Trying both pull-up settings in turn finds the one that gives edges
        if (tick) begin
          next_s.nosig_ms = s.nosig_ms + 12'h1;
          if (s.nosig_ms == 12'(PULL_TRY_MS - 1)) begin
            next_s.nosig_ms = 12'h0;
            next_s.auto_pull = !s.auto_pull;
          end
        end
        if (rise && p1_ok && s.w_ok) begin
          next_s.state = search_state;
          ev[EV_SEARCH] = 1'b1;
        end
      end
      search_state: begin
        if (rise && p2_ok) begin
          next_s.state = frame_reading_state;
          next_s.bit_cnt = 6'h0;
          ev[EV_READ] = 1'b1;
        end else if ((rise && !p1_ok) || (fall && !(w0_ok || w1_ok)) ||
                     s.period >= 12'(TIMEOUT_MS)) begin
          next_s.state = no_signal_state;
          ev[EV_LOST] = 1'b1;
        end
      end
      frame_reading_state: begin
        if (fall && (w0_ok || w1_ok)) begin
          next_s.frame = {w1_ok && !w0_ok, s.frame[FRAME_BITS-1:1]};
          if (s.bit_cnt != 6'h3f) next_s.bit_cnt = s.bit_cnt + 6'h1;
        end
        if (rise && p2_ok) begin
          if (s.bit_cnt == 6'(FRAME_BITS)) begin
            // Marker edge is second zero of the minute the frame names
            next_s.state = idle_state;
            next_s.min = 6'(s.frame[MIN_UNITS_LSB +: 4]) +
                         6'(s.frame[MIN_TENS_LSB +: 3]) * 6'h0a;
            next_s.hour = 5'(s.frame[HOUR_UNITS_LSB +: 4]) +
                          5'(s.frame[HOUR_TENS_LSB +: 2]) * 5'h0a;
            next_s.sec = 6'h0;
            next_s.sec_ms = 10'h0;
            next_s.synced = 1'b1;
            next_s.ever = 1'b1;
            ev[EV_SYNC] = 1'b1;
          end else begin
            next_s.state = search_state;
          end
        end else if ((rise && !p1_ok) || (fall && !(w0_ok || w1_ok)) ||
                     s.period >= 12'(TIMEOUT_MS)) begin
          next_s.state = no_signal_state;
          ev[EV_LOST] = 1'b1;
        end
      end
    endcase
    if (next_s.state != no_signal_state) next_s.nosig_ms = 12'h0;
    // ---------------------------------------------------------------
    // AHB-Lite slave, zero wait states
    // ---------------------------------------------------------------
    next_s.a_act = ap;
    next_s.a_wr = HWRITE;
    next_s.a_addr = {HADDR[7:2], 2'b00};
    if (ap && !HWRITE) begin
      next_s.rdata = 32'h0;
      unique case ({HADDR[7:2], 2'b00})
        CTRL_OFS: next_s.rdata = {21'h0, s.cfg.tol, 1'b0, s.cfg.led_mode, s.cfg.ps_inv,
                                  s.cfg.inv_mode, s.cfg.pull_mode};
        SYNC_OFS: next_s.rdata = {19'h0, s.cfg.sync_hour, 3'h0, s.cfg.rx_bright};
        TIME_OFS: next_s.rdata = {11'h0, s.hour, 2'h0, s.min, 2'h0, s.sec};
        STATUS_OFS: next_s.rdata = {18'h0, s.bit_cnt, 2'h0, s.auto_pull, s.auto_inv,
                                    s.ever, s.synced, s.state};
        INT_STAT_OFS: begin
          next_s.rdata = {27'h0, s.istat};
          clr = '1;
        end
        INT_MASK_OFS: next_s.rdata = {27'h0, s.imask};
        default: next_s.rdata = 32'h0;
      endcase
    end
    if (s.a_act && s.a_wr) begin
      unique case (s.a_addr)
        CTRL_OFS: begin
          if (HWDATA[PULL_LSB +: 2] != 2'h3) next_s.cfg.pull_mode = sel_t'(HWDATA[PULL_LSB +: 2]);
          if (HWDATA[INV_LSB +: 2] != 2'h3) next_s.cfg.inv_mode = sel_t'(HWDATA[INV_LSB +: 2]);
          next_s.cfg.ps_inv = HWDATA[PSINV_BIT];
          if (HWDATA[LED_LSB +: 2] <= LED_MAX) next_s.cfg.led_mode = HWDATA[LED_LSB +: 2];
          if (HWDATA[TOL_LSB +: 3] >= TOL_MIN && HWDATA[TOL_LSB +: 3] <= TOL_MAX) begin
            next_s.cfg.tol = HWDATA[TOL_LSB +: 3];
          end
        end
        SYNC_OFS: begin
          if (HWDATA[BRIGHT_LSB +: 5] <= BRIGHT_MAX) begin
            next_s.cfg.rx_bright = HWDATA[BRIGHT_LSB +: 5];
          end
          if (HWDATA[SHOUR_LSB +: 5] <= HOUR_MAX) begin
            next_s.cfg.sync_hour = HWDATA[SHOUR_LSB +: 5];
          end
        end
        TIME_OFS: begin
          // Manual time stops any attempt and runs free until the sync hour
          if (HWDATA[HOUR_LSB +: 5] <= HOUR_MAX && HWDATA[MIN_LSB +: 6] <= 6'h3b &&
              HWDATA[SEC_LSB +: 6] <= 6'h3b) begin
            next_s.hour = HWDATA[HOUR_LSB +: 5];
            next_s.min = HWDATA[MIN_LSB +: 6];
            next_s.sec = HWDATA[SEC_LSB +: 6];
            next_s.sec_ms = 10'h0;
            next_s.state = idle_state;
            next_s.synced = 1'b0;
          end
        end
        INT_MASK_OFS: next_s.imask = HWDATA[EV_W-1:0];
        default: ;
      endcase
    end
    // An event in the clearing cycle survives the read
    next_s.istat = (s.istat & ~clr) | ev;
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      s <= '0;
      s.state <= no_signal_state;
      s.cfg <= CFG_RST;
      s.auto_pull <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  always_comb begin
    unique case (s.cfg.led_mode)
      2'h0: led_en = !s.ever;
      2'h1: led_en = !s.synced;
      default: led_en = 1'b1;
    endcase
  end
  assign RX_LED = cond && led_en;
  assign PULLUP_EN = (s.cfg.pull_mode == forced_on) ? 1'b1 :
                     (s.cfg.pull_mode == forced_off) ? 1'b0 : s.auto_pull;
  assign RX_POWER = attempting ^ s.cfg.ps_inv;
  assign DISP_BLANK = attempting && (s.cfg.rx_bright == 5'h0);
  assign DISP_DIM = attempting && (s.cfg.rx_bright != 5'h0);
  assign DISP_LEVEL = s.cfg.rx_bright;
  assign STATUS_CODE = s.state;
  assign IRQ = |(s.istat & s.imask);
  assign HRDATA = s.rdata;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);

  a_clean_to_search: assert property (
    s.state == no_signal_state && rise && p1_ok && s.w_ok && !wr_time |=>
    s.state == search_state) else $error("clean pulse did not start search");
  a_gap_to_read: assert property (
    s.state == search_state && rise && p2_ok && !wr_time |=>
    s.state == frame_reading_state && s.bit_cnt == 6'h0) else $error("gap missed");
  a_short_frame: assert property (
    s.state == frame_reading_state && rise && p2_ok && s.bit_cnt != 6'(FRAME_BITS) &&
    !wr_time |=> s.state == search_state) else $error("short frame accepted");
  a_led_mode_two: assert property (
    s.cfg.led_mode == 2'h2 |-> RX_LED == (DATA_IN ^ inv_eff)) else $error("led not following");
  a_led_after_sync: assert property (
    s.cfg.led_mode == 2'h0 && s.ever |-> !RX_LED) else $error("led lit after sync");
  a_blank_zero: assert property (
    s.state != idle_state && s.cfg.rx_bright == 5'h0 |-> DISP_BLANK && !DISP_DIM)
    else $error("display not blanked");
  a_dim_level: assert property (
    s.state == search_state && s.cfg.rx_bright != 5'h0 |-> DISP_DIM && DISP_LEVEL != 5'h0)
    else $error("display not dimmed");
  a_hour_start: assert property (
    s.state == idle_state && sec_tick && s.hour == s.cfg.sync_hour && s.min == 6'h0 &&
    s.sec == 6'h0 && !wr_time |=> s.state == no_signal_state ##0 RX_POWER != s.cfg.ps_inv)
    else $error("scheduled attempt not started");
  a_pull_forced: assert property (
    s.cfg.pull_mode == forced_off |-> !PULLUP_EN) else $error("pull-up not off");
  a_power_pol: assert property (
    s.state == idle_state |-> RX_POWER == s.cfg.ps_inv) else $error("power polarity");
  a_tol_range: assert property (
    s.cfg.tol >= TOL_MIN && s.cfg.tol <= TOL_MAX) else $error("tolerance out of range");
  a_manual_time: assert property (
    wr_time && HWDATA[HOUR_LSB +: 5] <= HOUR_MAX && HWDATA[MIN_LSB +: 6] <= 6'h3b &&
    HWDATA[SEC_LSB +: 6] <= 6'h3b |=> s.state == idle_state && !s.synced)
    else $error("manual time not adopted");
  a_auto_polarity: assert property (
    tick && s.win == 10'(SEC_MS - 1) |=> s.auto_inv == $past(s.hi > s.lo))
    else $error("polarity vote wrong");
  c_search: cover property (s.state == no_signal_state ##1 s.state == search_state);
  c_read: cover property (s.state == search_state ##1 s.state == frame_reading_state);
  c_sync: cover property (s.state == frame_reading_state ##1 s.state == idle_state);
  c_irq: cover property (IRQ);
endmodule // time_signal_receiver_sync

// ===== tb/rx_model.sv
// Behavioural model of the demodulated long-wave receiver feeding the block
module rx_model import tsr_pkg::*; #(
  parameter int MS_CYCLES = 2
) (
  input wire logic clk,
  input wire logic power_pin,
  input wire logic power_inv,
  input wire logic pull_en,
  input wire logic out_inv,
  output logic data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic level;
  logic drv;
  logic powered;

  // ---------------------------------------------------------------
  // Output stage
  // ---------------------------------------------------------------
  // Module runs with its control pin high, or low when that pin is inverted
  assign powered = power_pin ^ power_inv;
  assign drv = level ^ out_inv;
  // Switched off, the line floats: pull-up level, else not the last value
  assign data = powered ? drv : (pull_en ? 1'b1 : ~drv);

  initial begin
    level = 1'b0;
  end

  // One second of carrier: a pulse of high_ms, or none for the minute marker
  task automatic second(input int high_ms);
    @(posedge clk);
    level <= (high_ms != 0);
    repeat (high_ms * MS_CYCLES) @(posedge clk);
    level <= 1'b0;
    repeat ((SEC_MS - high_ms) * MS_CYCLES - 1) @(posedge clk);
  endtask
endmodule // rx_model

// ===== tb/time_signal_receiver_sync_test.sv
// Self-checking bench for the time-signal receiver front end
module time_signal_receiver_sync_test import tsr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MS = 2;
  logic clk, rst, hsel, hwrite, hready, data_in, rx_inv, pwr_inv;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, status_code;
  logic [2:0] hsize;
  logic hreadyout, hresp, pullup_en, rx_power, rx_led, irq, disp_blank, disp_dim;
  logic [4:0] disp_level;
  int error_cnt, check_count;

  time_signal_receiver_sync #(.MS_CYCLES(MS)) u_dut (.CORE_CLK(clk), .SYS_RST(rst),
    .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize),
    .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hreadyout),
    .HRESP(hresp), .DATA_IN(data_in), .PULLUP_EN(pullup_en), .RX_POWER(rx_power),
    .RX_LED(rx_led), .IRQ(irq), .DISP_BLANK(disp_blank), .DISP_DIM(disp_dim),
    .DISP_LEVEL(disp_level), .STATUS_CODE(status_code));
  rx_model #(.MS_CYCLES(MS)) u_rx (.clk(clk), .power_pin(rx_power), .power_inv(pwr_inv),
    .pull_en(pullup_en), .out_inv(rx_inv), .data(data_in));
  assign hready = hreadyout;

  always #20 clk = ~clk;

  // ---------------------------------------------------------------
  // Bus and compare helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1; htrans <= 2'b10; hwrite <= wr; haddr <= {24'h0, a}; hsize <= 3'b010;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    #1;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    chk(status_code, 32'h1);
    chk({rx_power, pullup_en, disp_dim, disp_blank, irq}, 32'h1c);
    chk(disp_level, 32'h5);
    chk({hreadyout, hresp}, 32'h2);
    rd_chk(CTRL_OFS, 32'hffffffff, 32'h100);
    rd_chk(SYNC_OFS, 32'hffffffff, 32'h305);
    rd_chk(8'h20, 32'hffffffff, 32'h0);
  endtask

  task automatic t_pins;
    ahb(1'b1, CTRL_OFS, 32'h101);
    chk(pullup_en, 32'h1);
    ahb(1'b1, CTRL_OFS, 32'h102);
    chk(pullup_en, 32'h0);
    ahb(1'b1, CTRL_OFS, 32'h702);
    rd_chk(CTRL_OFS, 32'hffffffff, 32'h102);
    ahb(1'b1, CTRL_OFS, 32'h602);
    rd_chk(CTRL_OFS, 32'hffffffff, 32'h602);
    ahb(1'b1, CTRL_OFS, 32'h002);
    rd_chk(CTRL_OFS, 32'hffffffff, 32'h602);
    ahb(1'b1, CTRL_OFS, 32'h104);
    chk(rx_led, {31'h0, ~data_in});
    ahb(1'b1, CTRL_OFS, 32'h108);
    chk(rx_led, data_in);
    pwr_inv = 1'b1;
    ahb(1'b1, CTRL_OFS, 32'h110);
    chk(rx_power, 32'h0);
    pwr_inv = 1'b0;
    ahb(1'b1, CTRL_OFS, 32'h100);
    chk(rx_power, 32'h1);
  endtask

  task automatic t_display;
    ahb(1'b1, SYNC_OFS, 32'h1700);
    chk({disp_blank, disp_dim}, 32'h2);
    rd_chk(SYNC_OFS, 32'hffffffff, 32'h1700);
    ahb(1'b1, SYNC_OFS, 32'h1719);
    chk({disp_blank, disp_dim, disp_level}, 32'h39);
    ahb(1'b1, SYNC_OFS, 32'h181a);
    rd_chk(SYNC_OFS, 32'hffffffff, 32'h1719);
  endtask

  // Receiver wired inverted: the block must find the polarity on its own
  task automatic t_sync;
    rx_inv = 1'b1;
    ahb(1'b1, INT_MASK_OFS, 32'h1f);
    ahb(1'b0, INT_STAT_OFS, 32'h0);
    for (int i = 0; i < 12 && status_code !== 2'h2; i++) begin
      u_rx.second(BIT0_MS);
    end
    chk(status_code, 32'h2);
    rd_chk(STATUS_OFS, 32'h10, 32'h10);
    fork
      u_rx.second(BIT0_MS);
      begin repeat (50 * MS) @(posedge clk); #1; chk(rx_led, 32'h1); end
    join
    u_rx.second(0);
    fork
      u_rx.second(BIT1_MS);
      begin repeat (20 * MS) @(posedge clk); #1; chk(status_code, 32'h3); end
    join
    chk(irq, 32'h1);
    ahb(1'b1, INT_MASK_OFS, 32'h0);
    chk(irq, 32'h0);
    ahb(1'b1, INT_MASK_OFS, 32'h1f);
    chk(irq, 32'h1);
    rd_chk(INT_STAT_OFS, 32'h3, 32'h3);
    chk(irq, 32'h0);
    rd_chk(INT_STAT_OFS, 32'h3, 32'h0);
  endtask

  // Manual time stops the attempt and runs unsynchronised
  task automatic t_manual;
    ahb(1'b1, TIME_OFS, 32'h000c2238);
    chk({status_code, rx_power, disp_dim}, 32'h0);
    rd_chk(TIME_OFS, 32'h001f3f00, 32'h000c2200);
    rd_chk(STATUS_OFS, 32'h4, 32'h0);
    ahb(1'b1, TIME_OFS, 32'h00180000);
    rd_chk(TIME_OFS, 32'h001f3f00, 32'h000c2200);
    for (int m = 0; m < 3; m++) begin
      ahb(1'b1, CTRL_OFS, 32'h108 | (m << LED_LSB));
      chk(rx_led, data_in);
    end
    pwr_inv = 1'b1;
    ahb(1'b1, CTRL_OFS, 32'h110);
    chk(rx_power, 32'h1);
  endtask

  // ---------------------------------------------------------------
  // Run control
  // ---------------------------------------------------------------
  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    #4ms;
    error_cnt++;
    end_of_test();
  end

  initial begin
    clk = 1'b0; rst = 1'b1; hsel = 1'b0; hwrite = 1'b0; htrans = 2'b00; haddr = 32'h0;
    hsize = 3'b010; hwdata = 32'h0; rx_inv = 1'b0; pwr_inv = 1'b0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    t_reset();
    t_pins();
    t_display();
    t_sync();
    t_manual();
    end_of_test();
  end
endmodule // time_signal_receiver_sync_test
